// [inc/cfgload_pkg.sv]
// Purpose: shared constants and types of the configuration loader link
// Assumes: 40 ns system clock on both ends
// Notes: times are kept in ns and turned into cycle counts here
package cfgload_pkg;
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned SETTLE_NS = 500000;
  localparam int unsigned SETTLE_CYC = SETTLE_NS / CLK_PERIOD_NS;
  localparam int unsigned FETCH_NS = 10000;
  localparam int unsigned FETCH_CYC = FETCH_NS / CLK_PERIOD_NS;
  localparam int unsigned ERASE_NS = 20000000;
  localparam int unsigned ERASE_CYC = ERASE_NS / CLK_PERIOD_NS;
  localparam int unsigned BOOT_WAIT_NS = 1000000;
  localparam int unsigned BOOT_WAIT_CYC =
    (BOOT_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // slave address and register map
  localparam logic [4:0] SLAVE_ADDR_HI = 5'h13;
  localparam logic [15:0] NV_BASE = 16'hf800;
  localparam logic [15:0] NV_LAST = 16'hfbff;
  localparam logic [7:0] RAM_LAST = 8'hdf;
  localparam logic [7:0] REG_UPD_CTRL = 8'h90;
  localparam logic [7:0] REG_USER_DL = 8'hd8;
  localparam logic [7:0] REG_MAKER = 8'hf4;
  localparam logic [7:0] REG_REV = 8'hf5;
  localparam logic [7:0] REG_BRAND1 = 8'hf6;
  localparam logic [7:0] REG_BRAND2 = 8'hf7;
  localparam logic [7:0] UPD_RESET = 8'h00;
  localparam int unsigned UPD_TRANSPARENT = 0;
  localparam int unsigned UPD_COMMIT = 1;
  localparam int unsigned UPD_ERASE_EN = 2;
  localparam int unsigned UDL_RELOAD = 0;
  localparam logic [7:0] ERASE_CMD = 8'hfe;
  localparam logic [7:0] BLANK = 8'hff;
  // nonvolatile layout
  localparam int unsigned NV_DEPTH = 1024;
  localparam int unsigned PAGE_BYTES = 32;
  localparam int unsigned CFG_BYTES = 224;
  localparam logic [9:0] ENG_BASE = 10'h200;
  localparam logic [5:0] ENG_LAST_STATE = 6'h3e;
  // host register offsets (byte addresses)
  localparam logic [4:0] HOFS_TARGET = 5'h00;
  localparam logic [4:0] HOFS_WDATA = 5'h04;
  localparam logic [4:0] HOFS_CTRL = 5'h08;
  localparam logic [4:0] HOFS_STATUS = 5'h0c;
  localparam logic [4:0] HOFS_SLAVE = 5'h10;
  localparam logic [6:0] HOST_SLAVE_RESET = 7'h4c;
  typedef enum logic [1:0] {OP_WRITE, OP_READ, OP_ERASE, OP_POINT} op_t;
endpackage : cfgload_pkg

// [inc/cfg_link_if.sv]
// Purpose: byte-level serial link between bus master and loader
// Assumes: both ends on the same clock
// Notes: one byte outstanding; answer comes one cycle after the byte
`timescale 1ns/1ps
`default_nettype none
interface cfg_link_if;
  logic byte_valid;
  logic byte_first;
  logic byte_read;
  logic [7:0] byte_data;
  logic stop;
  logic resp_valid;
  logic resp_ack;
  logic [7:0] resp_data;
  modport dev_end (input byte_valid, byte_first, byte_read, byte_data, stop,
    output resp_valid, resp_ack, resp_data);
  modport host_end (output byte_valid, byte_first, byte_read, byte_data,
    stop, input resp_valid, resp_ack, resp_data);
endinterface : cfg_link_if
`default_nettype wire

// [rtl/nv_array.sv]
// Purpose: nonvolatile byte array with byte write and page erase
// Assumes: contents survive reset; starts blank in simulation
// Notes: two asynchronous read ports
`timescale 1ns/1ps
`default_nettype none
module nv_array (
  input wire logic clock,
  input wire logic wr_en,
  input wire logic [9:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic erase_en,
  input wire logic [4:0] erase_page,
  input wire logic [9:0] a_addr,
  output logic [7:0] a_data,
  input wire logic [9:0] b_addr,
  output logic [7:0] b_data
);
  import cfgload_pkg::*;
  logic [7:0] mem [0:NV_DEPTH-1];

  // blank array at start of simulation
  initial begin
    for (int i = 0; i < NV_DEPTH; i++) begin
      mem[i] = BLANK;
    end
  end

  // erase sets a whole page to ones, else single byte write
  always_ff @(posedge clock) begin
    if (erase_en) begin
      for (int i = 0; i < PAGE_BYTES; i++) begin
        mem[{erase_page, 5'(i)}] <= BLANK;
      end
    end else if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // read ports
  assign a_data = mem[a_addr];
  assign b_data = mem[b_addr];
endmodule : nv_array
`default_nettype wire

// [rtl/config_download_update_ctrl.sv]
// Purpose: device end: power-up download, staged update, nv access
// Assumes: lockout and address pins are asynchronous; eng_advance is local
// Notes: busy phases answer every byte with a not-acknowledge
//
// Register access over Avalon-MM was decided locally.
`timescale 1ns/1ps
`default_nettype none
// Function
// - start download once supply passes lockout
// - fill staging first, then commit all together
// - first state word loaded after settle delay
// - not-acknowledge until power-up download done
// - master waits about 1 ms after power-up
// - transparent bit writes both latch stages
// - otherwise writes reach staging latch only
// - commit bit pulses staging into active latches
// - nv writes leave volatile configuration alone
// - erase enable gates page erase to ones
// - erase enable bit 2, command 0xfe
// - not-acknowledge during page erase time
// - 63 states of 64 bits, one reserved
// - next state fetched on advance, 10 us
// - states live only in nv memory
// - first write byte loads address pointer
// - nv reachable at 0xf800 to 0xfbff
// - nv byte written only when blank
// - config pages 0-6, page 7 reserved
// - user download bit reloads pages 0-6
// - slave address 10011 plus two pins
// - read-only identification registers
// - master keeps nv writes rare
module config_download_update_ctrl #(
  parameter int unsigned SETTLE_CYCLES = cfgload_pkg::SETTLE_CYC,
  parameter int unsigned ERASE_CYCLES = cfgload_pkg::ERASE_CYC,
  parameter logic [7:0] MAKER_VALUE = 8'h5a, // arbitrary value
  parameter logic [7:0] REV_VALUE = 8'h07, // arbitrary value
  parameter logic [7:0] BRAND1_VALUE = 8'h33, // arbitrary value
  parameter logic [7:0] BRAND2_VALUE = 8'h34 // arbitrary value
) (
  input wire logic clock,
  input wire logic rst,
  cfg_link_if.dev_end link,
  input wire logic undervoltage_lockout_ok,
  input wire logic addr_select_low,
  input wire logic addr_select_high,
  input wire logic eng_advance,
  input wire logic [7:0] cfg_addr,
  output logic [7:0] cfg_data,
  output logic [63:0] state_engine_word,
  output logic [5:0] state_engine_index,
  output logic state_engine_loaded
);
  import cfgload_pkg::*;
  typedef enum logic [2:0] {ST_WAIT_SUPPLY, ST_LOAD, ST_SETTLE, ST_FETCH,
    ST_RUN} boot_t;

  boot_t boot_reg, boot_next;
  logic sup_s1_reg, sup_s2_reg;
  logic [1:0] asel_s1_reg, asel_s2_reg;
  logic [13:0] boot_cnt_reg;
  logic [18:0] erase_cnt_reg;
  logic reload_reg, commit_reg;
  logic [7:0] upd_reg, udl_reg;
  logic [15:0] ptr_reg;
  logic addressed_reg, rw_reg, hi_reg;
  logic [1:0] nbyte_reg;
  logic resp_valid_reg, resp_ack_reg;
  logic [7:0] resp_data_reg, cfg_data_reg;
  logic [63:0] eng_word_reg;
  logic [5:0] eng_index_reg;
  logic eng_loaded_reg;
  logic [7:0] stage_mem [0:CFG_BYTES-1];
  logic [7:0] active_mem [0:CFG_BYTES-1];
  logic [7:0] nv_a_data, nv_b_data;
  logic [9:0] nv_b_addr;

  // decode of the incoming byte
  wire [7:0] bd = link.byte_data;
  wire erase_busy = erase_cnt_reg != 19'h0;
  wire busy = boot_reg == ST_WAIT_SUPPLY || boot_reg == ST_LOAD ||
    commit_reg || erase_busy;
  wire addr_hit = bd[7:1] == {SLAVE_ADDR_HI, asel_s2_reg};
  wire wr_byte = link.byte_valid && !link.byte_first && !link.byte_read &&
    addressed_reg && !rw_reg && !busy;
  wire rd_byte = link.byte_valid && link.byte_read && addressed_reg &&
    rw_reg && !busy;
  wire first_data = wr_byte && nbyte_reg == 2'd0;
  wire is_hi = bd[7:2] == NV_BASE[15:10];
  wire erase_cmd = first_data && bd == ERASE_CMD;
  wire set_lo_hi = wr_byte && nbyte_reg == 2'd1 && hi_reg;
  wire data_wr = wr_byte && !first_data && !set_lo_hi;
  wire ptr_nv = ptr_reg >= NV_BASE && ptr_reg <= NV_LAST;
  wire ptr_ram = ptr_reg[15:8] == 8'h00 && ptr_reg[7:0] <= RAM_LAST;
  wire ptr_upd = ptr_reg == {8'h00, REG_UPD_CTRL};
  wire ptr_udl = ptr_reg == {8'h00, REG_USER_DL};
  wire nv_wr = data_wr && ptr_nv && nv_a_data == BLANK;
  wire erase_go = erase_cmd && upd_reg[UPD_ERASE_EN] && ptr_nv;
  wire ctl_wr = data_wr && (ptr_upd || ptr_udl);
  wire ram_wr = data_wr && ptr_ram && !ptr_upd && !ptr_udl;
  wire commit_req = data_wr && ptr_upd && bd[UPD_COMMIT];
  wire reload_req = data_wr && ptr_udl && bd[UDL_RELOAD];
  wire load_done = boot_reg == ST_LOAD &&
    boot_cnt_reg == 14'(CFG_BYTES - 1);
  wire settle_done = boot_cnt_reg == 14'(SETTLE_CYCLES - 1);
  wire fetch_done = boot_cnt_reg == 14'(FETCH_CYC - 1);
  wire byte_ack = link.byte_first ? addr_hit && !busy : (wr_byte || rd_byte);

  // read selection at the pointer
  wire [7:0] rd_val = ptr_nv ? nv_a_data :
    ptr_upd ? upd_reg :
    ptr_udl ? udl_reg :
    ptr_ram ? stage_mem[ptr_reg[7:0]] :
    ptr_reg == {8'h00, REG_MAKER} ? MAKER_VALUE :
    ptr_reg == {8'h00, REG_REV} ? REV_VALUE :
    ptr_reg == {8'h00, REG_BRAND1} ? BRAND1_VALUE :
    ptr_reg == {8'h00, REG_BRAND2} ? BRAND2_VALUE : 8'h00;

  // loader reads config pages, engine reads the state array
  assign nv_b_addr = boot_reg == ST_LOAD ? boot_cnt_reg[9:0] :
    ENG_BASE + {1'b0, eng_index_reg, boot_cnt_reg[2:0]};

  nv_array nv (
    .clock(clock),
    .wr_en(nv_wr),
    .wr_addr(ptr_reg[9:0]),
    .wr_data(bd),
    .erase_en(erase_go),
    .erase_page(ptr_reg[9:5]),
    .a_addr(ptr_reg[9:0]),
    .a_data(nv_a_data),
    .b_addr(nv_b_addr),
    .b_data(nv_b_data)
  );

  // pin synchronisers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sup_s1_reg <= 1'b0;
      sup_s2_reg <= 1'b0;
      asel_s1_reg <= 2'b00;
      asel_s2_reg <= 2'b00;
    end else begin
      sup_s1_reg <= undervoltage_lockout_ok;
      sup_s2_reg <= sup_s1_reg;
      asel_s1_reg <= {addr_select_high, addr_select_low};
      asel_s2_reg <= asel_s1_reg;
    end
  end

  // boot and fetch sequence
  always_comb begin
    boot_next = boot_reg;
    case (boot_reg)
      ST_WAIT_SUPPLY: if (sup_s2_reg) boot_next = ST_LOAD;
      ST_LOAD: if (load_done) boot_next = reload_reg ? ST_RUN : ST_SETTLE;
      ST_SETTLE: if (settle_done) boot_next = ST_FETCH;
      ST_FETCH: if (fetch_done) boot_next = ST_RUN;
      ST_RUN: begin
        if (reload_req) begin
          boot_next = ST_LOAD;
        end else if (eng_advance && eng_index_reg != ENG_LAST_STATE) begin
          boot_next = ST_FETCH;
        end
      end
      default: boot_next = ST_WAIT_SUPPLY;
    endcase
  end

  // sequence state, counters and engine word
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      boot_reg <= ST_WAIT_SUPPLY;
      boot_cnt_reg <= 14'h0;
      reload_reg <= 1'b0;
      eng_word_reg <= 64'h0;
      eng_index_reg <= 6'h0;
      eng_loaded_reg <= 1'b0;
    end else begin
      boot_reg <= boot_next;
      boot_cnt_reg <= boot_next != boot_reg ? 14'h0 : boot_cnt_reg + 14'h1;
      if (boot_reg == ST_RUN && reload_req) reload_reg <= 1'b1;
      else if (load_done) reload_reg <= 1'b0;
      if (boot_reg == ST_FETCH && boot_cnt_reg < 14'h8) begin
        eng_word_reg[{boot_cnt_reg[2:0], 3'b000} +: 8] <= nv_b_data;
      end
      if (boot_reg == ST_FETCH && fetch_done) eng_loaded_reg <= 1'b1;
      if (boot_next == ST_FETCH && boot_reg == ST_RUN) begin
        eng_index_reg <= eng_index_reg + 6'h1;
        eng_loaded_reg <= 1'b0;
      end
    end
  end

  // control registers, erase timer, commit pulse
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      upd_reg <= UPD_RESET;
      udl_reg <= 8'h00;
      erase_cnt_reg <= 19'h0;
      commit_reg <= 1'b0;
    end else begin
      if (ctl_wr && ptr_upd) upd_reg <= bd & ~(8'h1 << UPD_COMMIT);
      if (ctl_wr && ptr_udl) udl_reg <= bd;
      else if (load_done) udl_reg[UDL_RELOAD] <= 1'b0;
      if (erase_go) erase_cnt_reg <= 19'(ERASE_CYCLES);
      else if (erase_busy) erase_cnt_reg <= erase_cnt_reg - 19'h1;
      commit_reg <= load_done || commit_req;
    end
  end

  // staging latches: filled by download or by bus writes
  always_ff @(posedge clock) begin
    if (boot_reg == ST_LOAD) begin
      stage_mem[boot_cnt_reg[7:0]] <= nv_b_data;
    end else if (ram_wr) begin
      stage_mem[ptr_reg[7:0]] <= bd;
    end
  end

  // active latches: one-step commit or transparent write
  always_ff @(posedge clock) begin
    if (commit_reg) begin
      for (int i = 0; i < CFG_BYTES; i++) begin
        active_mem[i] <= stage_mem[i];
      end
    end else if (ram_wr && upd_reg[UPD_TRANSPARENT]) begin
      active_mem[ptr_reg[7:0]] <= bd;
    end
  end

  // bus transaction tracking and answers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ptr_reg <= 16'h0;
      addressed_reg <= 1'b0;
      rw_reg <= 1'b0;
      hi_reg <= 1'b0;
      nbyte_reg <= 2'd0;
      resp_valid_reg <= 1'b0;
      resp_ack_reg <= 1'b0;
      resp_data_reg <= 8'h00;
    end else begin
      resp_valid_reg <= link.byte_valid;
      resp_ack_reg <= link.byte_valid && byte_ack;
      resp_data_reg <= rd_byte ? rd_val : 8'h00;
      if (link.stop) begin
        addressed_reg <= 1'b0;
      end else if (link.byte_valid && link.byte_first) begin
        addressed_reg <= addr_hit && !busy;
        rw_reg <= bd[0];
        nbyte_reg <= 2'd0;
      end
      if (wr_byte && nbyte_reg != 2'd3) nbyte_reg <= nbyte_reg + 2'd1;
      if (first_data && !erase_cmd) begin
        ptr_reg <= is_hi ? {bd, 8'h00} : {8'h00, bd};
        hi_reg <= is_hi;
      end
      if (set_lo_hi) ptr_reg[7:0] <= bd;
    end
  end

  // function-side view of the active configuration
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cfg_data_reg <= 8'h00;
    end else begin
      cfg_data_reg <= cfg_addr <= RAM_LAST ? active_mem[cfg_addr] : 8'h00;
    end
  end

  assign link.resp_valid = resp_valid_reg;
  assign link.resp_ack = resp_ack_reg;
  assign link.resp_data = resp_data_reg;
  assign cfg_data = cfg_data_reg;
  assign state_engine_word = eng_word_reg;
  assign state_engine_index = eng_index_reg;
  assign state_engine_loaded = eng_loaded_reg;
endmodule : config_download_update_ctrl
`default_nettype wire

// [rtl/config_bus_master.sv]
// Purpose: master end: turns Avalon-MM commands into link byte sequences
// Assumes: device answers every byte with one resp_valid pulse
// Notes: a not-acknowledge ends the sequence with a stop
`timescale 1ns/1ps
`default_nettype none
module config_bus_master #(
  parameter int unsigned BOOT_WAIT_CYCLES = cfgload_pkg::BOOT_WAIT_CYC
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  cfg_link_if.host_end link
);
  import cfgload_pkg::*;
  typedef enum logic [1:0] {H_BOOT, H_IDLE, H_ISSUE, H_WAIT} host_t;

  host_t st_reg;
  logic [14:0] boot_cnt_reg;
  logic [15:0] target_reg;
  logic [7:0] wdata_reg, rdata_reg;
  logic [6:0] slave_reg;
  op_t op_reg;
  logic nack_reg;
  logic [2:0] step_reg;
  logic wait_reg;
  logic [31:0] rdout_reg;
  logic valid_reg, first_reg, read_reg, stop_reg;
  logic [7:0] data_reg;
  logic it_first, it_read, it_stop, it_end;
  logic [7:0] it_byte;

  // Avalon decode
  wire take = (avs_read || avs_write) && wait_reg;
  wire busy = st_reg == H_ISSUE || st_reg == H_WAIT;
  wire go = take && avs_write && avs_address == HOFS_CTRL &&
    avs_writedata[0] && st_reg == H_IDLE;
  wire is_nv = target_reg[15:10] == NV_BASE[15:10];
  wire [2:0] p = is_nv ? 3'd3 : 3'd2;
  wire [31:0] rd_mux = avs_address == HOFS_TARGET ? {16'h0, target_reg} :
    avs_address == HOFS_WDATA ? {24'h0, wdata_reg} :
    avs_address == HOFS_CTRL ? {29'h0, op_reg, 1'b0} :
    avs_address == HOFS_STATUS ?
      {21'h0, rdata_reg, nack_reg, busy, st_reg != H_BOOT} :
    avs_address == HOFS_SLAVE ? {25'h0, slave_reg} : 32'h0;

  // next item of the byte sequence for the current command
  always_comb begin
    it_first = 1'b0;
    it_read = 1'b0;
    it_stop = 1'b0;
    it_end = 1'b0;
    it_byte = 8'h00;
    if (step_reg == 3'd0) begin
      it_first = 1'b1;
      it_byte = {slave_reg, 1'b0};
    end else if (op_reg == OP_ERASE) begin
      it_byte = ERASE_CMD;
      it_stop = step_reg == 3'd2;
      it_end = step_reg > 3'd2;
    end else if (step_reg < p) begin
      it_byte = (is_nv && step_reg == 3'd1) ? target_reg[15:8] :
        target_reg[7:0];
    end else if (op_reg == OP_WRITE) begin
      it_byte = wdata_reg;
      it_stop = step_reg == p + 3'd1;
      it_end = step_reg > p + 3'd1;
    end else if (op_reg == OP_POINT) begin
      it_stop = step_reg == p;
      it_end = step_reg > p;
    end else begin
      it_stop = step_reg == p || step_reg == p + 3'd3;
      it_first = step_reg == p + 3'd1;
      it_read = step_reg == p + 3'd2;
      it_byte = it_first ? {slave_reg, 1'b1} : 8'h00;
      it_end = step_reg > p + 3'd3;
    end
  end

  // Avalon slave: answer one cycle after the request is seen
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wait_reg <= 1'b1;
      rdout_reg <= 32'h0;
      target_reg <= 16'h0;
      wdata_reg <= 8'h00;
      slave_reg <= HOST_SLAVE_RESET;
      op_reg <= OP_WRITE;
    end else begin
      wait_reg <= !take;
      if (take && avs_read) rdout_reg <= rd_mux;
      if (take && avs_write && !busy) begin
        if (avs_address == HOFS_TARGET) target_reg <= avs_writedata[15:0];
        if (avs_address == HOFS_WDATA) wdata_reg <= avs_writedata[7:0];
        if (avs_address == HOFS_SLAVE) slave_reg <= avs_writedata[6:0];
        if (avs_address == HOFS_CTRL) op_reg <= op_t'(avs_writedata[2:1]);
      end
    end
  end

  // link sequencer
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_reg <= H_BOOT;
      boot_cnt_reg <= 15'h0;
      step_reg <= 3'd0;
      nack_reg <= 1'b0;
      rdata_reg <= 8'h00;
      valid_reg <= 1'b0;
      first_reg <= 1'b0;
      read_reg <= 1'b0;
      stop_reg <= 1'b0;
      data_reg <= 8'h00;
    end else begin
      valid_reg <= 1'b0;
      stop_reg <= 1'b0;
      case (st_reg)
        H_BOOT: begin
          boot_cnt_reg <= boot_cnt_reg + 15'h1;
          if (boot_cnt_reg == 15'(BOOT_WAIT_CYCLES - 1)) st_reg <= H_IDLE;
        end
        H_IDLE: begin
          if (go) begin
            st_reg <= H_ISSUE;
            step_reg <= 3'd0;
            nack_reg <= 1'b0;
          end
        end
        H_ISSUE: begin
          if (it_end) begin
            st_reg <= H_IDLE;
          end else if (it_stop) begin
            stop_reg <= 1'b1;
            step_reg <= step_reg + 3'd1;
          end else begin
            valid_reg <= 1'b1;
            first_reg <= it_first;
            read_reg <= it_read;
            data_reg <= it_byte;
            st_reg <= H_WAIT;
          end
        end
        H_WAIT: begin
          if (link.resp_valid) begin
            if (!link.resp_ack) begin
              nack_reg <= 1'b1;
              stop_reg <= 1'b1;
              st_reg <= H_IDLE;
            end else begin
              if (read_reg) rdata_reg <= link.resp_data;
              step_reg <= step_reg + 3'd1;
              st_reg <= H_ISSUE;
            end
          end
        end
        default: st_reg <= H_IDLE;
      endcase
    end
  end

  assign avs_readdata = rdout_reg;
  assign avs_waitrequest = wait_reg;
  assign link.byte_valid = valid_reg;
  assign link.byte_first = first_reg;
  assign link.byte_read = read_reg;
  assign link.byte_data = data_reg;
  assign link.stop = stop_reg;
endmodule : config_bus_master
`default_nettype wire

// [verif/cfgload_properties.sv]
// Purpose: link properties between master end and device end
// Assumes: one clock, rst async active high
// Notes: age_reg counts cycles since reset release
`timescale 1ns/1ps
`default_nettype none
module cfgload_properties #(
  parameter int unsigned BOOT_WAIT_CYCLES = 10
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic byte_valid,
  input wire logic byte_first,
  input wire logic byte_read,
  input wire logic [7:0] byte_data,
  input wire logic stop,
  input wire logic resp_valid,
  input wire logic resp_ack,
  input wire logic [7:0] resp_data
);
  import cfgload_pkg::*;
  logic [31:0] age_reg;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // saturating age since reset
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      age_reg <= 32'h0;
    end else if (age_reg != 32'hffffffff) begin
      age_reg <= age_reg + 32'h1;
    end
  end
  // address byte with wrong fixed bits, and a refusal
  sequence s_stranger;
    byte_valid && byte_first && (byte_data[7:3] != SLAVE_ADDR_HI);
  endsequence
  sequence s_nack;
    resp_valid && !resp_ack;
  endsequence
  a_answer_next: assert property (byte_valid |=> resp_valid)
    else $error("byte not answered next cycle");
  a_nack_empty: assert property (s_nack |-> resp_data == 8'h00)
    else $error("refusal carries data");
  a_write_empty: assert property (
    resp_valid && !$past(byte_read) |-> resp_data == 8'h00)
    else $error("data on a write answer");
  a_boot_refuse: assert property (
    resp_valid && age_reg < 32'd200 |-> !resp_ack)
    else $error("ack before download done");
  a_wrong_addr: assert property (s_stranger |=> s_nack)
    else $error("foreign address acknowledged");
  a_boot_quiet: assert property (
    age_reg < BOOT_WAIT_CYCLES |-> !byte_valid)
    else $error("byte sent during boot wait");
  a_stop_alone: assert property (stop |-> !byte_valid)
    else $error("stop together with a byte");
  a_one_outstanding: assert property (byte_valid |=> !byte_valid)
    else $error("byte sent before answer");
endmodule : cfgload_properties
`default_nettype wire

// [verif/testbench.sv]
// Purpose: bench for master and device ends joined by the link
// Assumes: short settle, erase and boot counts
// Notes: ordinary operations run from a row table
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import cfgload_pkg::*;
  typedef struct {op_t op; logic [15:0] tgt; logic [7:0] wd, rdat, act;
    logic nack; int idle;} row_t;
  logic clock, rst, supply_ok, sel_low, sel_high, eng_adv, eng_loaded;
  logic avs_read, avs_write, avs_waitrequest;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [7:0] cfg_addr, cfg_data;
  logic [63:0] eng_word;
  logic [5:0] eng_index;
  int fail_count, compares, n;
  // op, target, write, read back, active 0x10, refused, idle
  row_t rows[21] = '{
    '{OP_WRITE, 16'h0010, 8'h55, 8'h00, 8'hff, 1'b0, 0},
    '{OP_READ, 16'h0010, 8'h00, 8'h55, 8'hff, 1'b0, 0},
    '{OP_WRITE, 16'h0090, 8'h02, 8'h00, 8'h55, 1'b0, 0},
    '{OP_WRITE, 16'h0090, 8'h01, 8'h00, 8'h55, 1'b0, 0},
    '{OP_WRITE, 16'h0010, 8'h66, 8'h00, 8'h66, 1'b0, 0},
    '{OP_WRITE, 16'hf810, 8'h12, 8'h00, 8'h66, 1'b0, 0},
    '{OP_POINT, 16'hf810, 8'h00, 8'h00, 8'h66, 1'b0, 0},
    '{OP_ERASE, 16'hf810, 8'h00, 8'h00, 8'h66, 1'b0, 0},
    '{OP_READ, 16'hf810, 8'h00, 8'h12, 8'h66, 1'b0, 0},
    '{OP_WRITE, 16'hf810, 8'h34, 8'h00, 8'h66, 1'b0, 0},
    '{OP_READ, 16'hf810, 8'h00, 8'h12, 8'h66, 1'b0, 0},
    '{OP_WRITE, 16'h00d8, 8'h01, 8'h00, 8'h66, 1'b0, 0},
    '{OP_READ, 16'h00d8, 8'h00, 8'h00, 8'h12, 1'b0, 300},
    '{OP_WRITE, 16'h00f4, 8'h00, 8'h00, 8'h12, 1'b0, 0},
    '{OP_READ, 16'h00f4, 8'h00, 8'h5a, 8'h12, 1'b0, 0},
    '{OP_READ, 16'h00f7, 8'h00, 8'h34, 8'h12, 1'b0, 0},
    '{OP_WRITE, 16'h0090, 8'h04, 8'h00, 8'h12, 1'b0, 0},
    '{OP_POINT, 16'hf810, 8'h00, 8'h00, 8'h12, 1'b0, 0},
    '{OP_ERASE, 16'hf810, 8'h00, 8'h00, 8'h12, 1'b0, 0},
    '{OP_READ, 16'hf810, 8'h00, 8'h00, 8'h12, 1'b1, 0},
    '{OP_READ, 16'hf810, 8'h00, 8'hff, 8'h12, 1'b0, 70}};
  logic [31:0] slave_tab[3] = '{32'h4c, 32'h0e, 32'h4e};
  cfg_link_if link ();
  config_download_update_ctrl #(.SETTLE_CYCLES(20), .ERASE_CYCLES(60))
    config_download_update_ctrl_i (.clock(clock), .rst(rst),
    .link(link.dev_end), .undervoltage_lockout_ok(supply_ok),
    .addr_select_low(sel_low), .addr_select_high(sel_high),
    .eng_advance(eng_adv), .cfg_addr(cfg_addr), .cfg_data(cfg_data),
    .state_engine_word(eng_word), .state_engine_index(eng_index),
    .state_engine_loaded(eng_loaded));
  config_bus_master #(.BOOT_WAIT_CYCLES(10)) config_bus_master_i (
    .clock(clock), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .link(link.host_end));
  cfgload_properties #(.BOOT_WAIT_CYCLES(10)) cfgload_properties_i (
    .clock(clock), .rst(rst), .byte_valid(link.byte_valid),
    .byte_first(link.byte_first), .byte_read(link.byte_read),
    .byte_data(link.byte_data), .stop(link.stop),
    .resp_valid(link.resp_valid), .resp_ack(link.resp_ack),
    .resp_data(link.resp_data));
  // 25 MHz clock
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  task automatic conclude;
    if (fail_count == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : conclude
  task automatic stall;
    $display("unexpected at %0t: wait ran out", $time);
    fail_count++;
    conclude();
  endtask : stall
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  // one avalon cycle held until waitrequest is seen low
  task automatic av(input logic wr, input logic [4:0] a,
      input logic [31:0] d);
    int k;
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    for (k = 0; k < 50; k++) begin
      @(posedge clock);
      if (avs_waitrequest === 1'b0) break;
    end
    if (k == 50) stall();
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : av
  // one link operation, polled until no longer busy
  task automatic op(input op_t o, input logic [15:0] t,
      input logic [7:0] w);
    int k;
    av(1'b1, HOFS_TARGET, {16'h0, t});
    av(1'b1, HOFS_WDATA, {24'h0, w});
    av(1'b1, HOFS_CTRL, {29'h0, o, 1'b1});
    for (k = 0; k < 200; k++) begin
      av(1'b0, HOFS_STATUS, 32'h0);
      if (rd[1] === 1'b0) break;
    end
    if (k == 200) stall();
  endtask : op
  task automatic wait_eng(input logic [5:0] idx);
    int k;
    for (k = 0; k < 600; k++) begin
      @(negedge clock);
      if (eng_loaded === 1'b1 && eng_index === idx) break;
    end
    if (k == 600) stall();
  endtask : wait_eng
  // main sequence: boot, rows, then awkward cases
  initial begin
    fail_count = 0;
    compares = 0;
    rst = 1'b1;
    supply_ok = 1'b0;
    sel_low = 1'b0;
    sel_high = 1'b1;
    eng_adv = 1'b0;
    cfg_addr = 8'h10;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    for (n = 0; n < 100; n++) begin
      av(1'b0, HOFS_STATUS, 32'h0);
      if (rd[0] === 1'b1) break;
    end
    if (n == 100) stall();
    av(1'b1, HOFS_SLAVE, 32'h4e);
    op(OP_READ, 16'h00f4, 8'h00);
    chk(rd[2], 1'b1);
    @(posedge clock);
    supply_ok <= 1'b1;
    repeat (300) @(posedge clock);
    wait_eng(6'h00);
    chk(eng_word, 64'hffffffffffffffff);
    foreach (rows[i]) begin
      repeat (rows[i].idle) @(posedge clock);
      op(rows[i].op, rows[i].tgt, rows[i].wd);
      chk(rd[2], rows[i].nack);
      if (rows[i].op == OP_READ && !rows[i].nack) chk(rd[10:3], rows[i].rdat);
      chk(cfg_data, rows[i].act);
    end
    op(OP_WRITE, 16'hfa08, 8'ha5);
    @(posedge clock);
    eng_adv <= 1'b1;
    @(posedge clock);
    eng_adv <= 1'b0;
    wait_eng(6'h01);
    chk(eng_word, 64'hffffffffffffffa5);
    for (n = 0; n < 3; n++) begin
      av(1'b1, HOFS_SLAVE, slave_tab[n]);
      op(OP_READ, 16'h00f4, 8'h00);
      chk(rd[2], n < 2);
    end
    sel_low <= 1'b1;
    av(1'b1, HOFS_SLAVE, 32'h4f);
    op(OP_READ, 16'h00f4, 8'h00);
    chk(rd[2], 1'b0);
    @(posedge clock);
    rst <= 1'b1;
    @(negedge clock);
    chk({eng_loaded, cfg_data, avs_waitrequest}, 10'h001);
    @(posedge clock);
    rst <= 1'b0;
    av(1'b0, HOFS_STATUS, 32'h0);
    chk(rd[2:0], 3'h0);
    conclude();
  end
endmodule : testbench
`default_nettype wire
